// file: hdl/dap_fabric_pkg.sv
// Shared constants of the debug access port fabric
package dap_fabric_pkg;
	localparam int ADDR_W = 12;
	localparam int TRACE_W = 4;
	localparam int CT_CH = 2;
	localparam int CH_HALT = 0;
	localparam int CH_RESTART = 1;
	localparam logic [1:0] AP_LP = 2'h0;
	localparam logic [1:0] AP_HP = 2'h1;
	localparam logic [1:0] AP_SYS = 2'h2;
	localparam logic [2:0] AP_EN_RST = 3'h6;
	localparam logic [1:0] CTL_RST = 2'h0;
	localparam logic TRACE_ON_RST = 1'b1;
	localparam logic [11:0] ROM_PTR_OFS = 12'hFF8;
	localparam logic [11:0] ROM_ENTRY0_OFS = 12'hF00;
	localparam logic [11:0] ROM_PID0_OFS = 12'hFE0;
	localparam logic [11:0] ROM_PID1_OFS = 12'hFE4;
	localparam logic [11:0] ROM_REV_OFS = 12'hFE8;
	localparam logic [11:0] ROM_CID_OFS = 12'hFF0;
	localparam logic [31:0] ROM_END_MARK = 32'h0000_0000;
	localparam logic [1:0] MTB_WIN = 2'h1;
	localparam logic [1:0] PERIPH_WIN = 2'h2;
	localparam int DBG_REQ_BIT = 28;
	localparam int DBG_ACK_BIT = 29;
	localparam int SYS_REQ_BIT = 30;
	localparam int SYS_ACK_BIT = 31;
endpackage

// file: hdl/level_sync3.sv
// Three-stage level synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module level_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import dap_fabric_pkg::*;
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// A bit moves only once stages two and three agree
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			sync_o <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sync_o <= (s2_q & s3_q) | (sync_o & (s2_q | s3_q));
		end
	end
endmodule
`default_nettype wire

// file: hdl/pulse_handshake.sv
// Toggle handshake carrying single pulses between two clocks
`timescale 1ns/100ps
`default_nettype none
module pulse_handshake (
	input wire logic src_clk_i,
	input wire logic dst_clk_i,
	input wire logic reset_n_i,
	input wire logic src_pulse_i,
	output logic src_busy_o,
	output logic dst_pulse_o
);
	import dap_fabric_pkg::*;
	logic req_q;
	logic pend_q;
	logic ack1_q;
	logic ack2_q;
	logic req1_q;
	logic req2_q;
	logic req3_q;

	assign src_busy_o = req_q ^ ack2_q;

	// Pulses during a round trip wait in pend_q; several merge into one
	always_ff @(posedge src_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_q <= 1'b0;
			pend_q <= 1'b0;
			ack1_q <= 1'b0;
			ack2_q <= 1'b0;
		end else begin
			ack1_q <= req2_q;
			ack2_q <= ack1_q;
			if (!src_busy_o && (src_pulse_i || pend_q)) begin
				req_q <= ~req_q;
				pend_q <= 1'b0;
			end else if (src_pulse_i) begin
				pend_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge dst_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req1_q <= 1'b0;
			req2_q <= 1'b0;
			req3_q <= 1'b0;
			dst_pulse_o <= 1'b0;
		end else begin
			req1_q <= req_q;
			req2_q <= req1_q;
			req3_q <= req2_q;
			dst_pulse_o <= req2_q ^ req3_q;
		end
	end

	AST_HS_LAUNCH: assert property (@(posedge src_clk_i) disable iff (!reset_n_i)
		src_pulse_i && !src_busy_o |=> src_busy_o)
		else $error("handshake did not launch");
	AST_HS_SINGLE: assert property (@(posedge dst_clk_i) disable iff (!reset_n_i)
		dst_pulse_o |=> !dst_pulse_o)
		else $error("handshake pulse duplicated");
endmodule
`default_nettype wire

// file: hdl/debug_access_port_fabric.sv
// Debug access port fabric: link front end, port routing, trace and cross triggers
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Four-wire link active by default; two-wire when selected; never both at once.
// - Each access goes to at most one of the three access ports.
// - Low-power core port drives that core's slave port and bus master.
// - Low-power core port is off after reset until policy enables it.
// - High-perf core port reaches its debug parts over the external peripheral bus.
// - Only the system port reaches the system ROM table, which holds identity only.
// - High-perf and system ports open by default; policy may close both.
// - Link logic answers while the system sleeps; access ports need power.
// - Control status holds debug and system power requests driving power outputs.
// - Two-wire pins work always; four-wire link only in active mode.
// - Four-wire link becomes available only after power-on reset.
// - Each access port answers its root ROM table pointer locally.
// - ROM tables hold entries plus shared identity and component words.
// - Micro trace buffer stores low-power core flow; host reads it back.
// - Two trace byte streams merge into the trace port unit pins.
// - High-perf trigger interface runs fast; matrix and others run slow.
// - Trigger channels halt or restart both cores; trace stops when full.
module debug_access_port_fabric #(
	parameter int MTB_DEPTH = 64,
	parameter logic [31:0] LP_ROM_BASE = 32'hF000_0000,
	parameter logic [31:0] HP_ROM_BASE = 32'hE00F_F000,
	parameter logic [31:0] SYS_ROM_BASE = 32'hF000_1000,
	parameter logic [31:0] ID_MAKER = 32'h0000_0055, // arbitrary
	parameter logic [31:0] ID_PART = 32'h0000_0123, // arbitrary
	parameter logic [31:0] ID_REVISION = 32'h0000_0010, // arbitrary
	parameter logic [31:0] ID_COMPONENT = 32'h0000_0001 // arbitrary
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic link_clk_i,
	input wire logic fast_clk_i,
	input wire logic link_swd_sel_i,
	input wire logic link_req_i,
	input wire logic link_dp_i,
	input wire logic link_write_i,
	input wire logic [1:0] link_ap_sel_i,
	input wire logic [dap_fabric_pkg::ADDR_W-1:0] link_addr_i,
	input wire logic [31:0] link_wdata_i,
	output logic link_busy_o,
	output logic link_done_o,
	output logic link_fault_o,
	output logic [31:0] link_rdata_o,
	output logic swd_active_o,
	output logic jtag_active_o,
	input wire logic active_mode_i,
	input wire logic debug_pwr_ack_i,
	input wire logic system_pwr_ack_i,
	output logic debug_power_up_request_o,
	output logic system_power_up_request_o,
	input wire logic policy_valid_i,
	input wire logic [2:0] policy_ap_en_i,
	output logic [2:0] ap_req_o,
	output logic ap_write_o,
	output logic [dap_fabric_pkg::ADDR_W-1:0] ap_addr_o,
	output logic [31:0] ap_wdata_o,
	output logic external_peripheral_bus_sel_o,
	input wire logic ap_ack_i,
	input wire logic [31:0] ap_rdata_i,
	input wire logic lp_trace_valid_i,
	input wire logic [31:0] lp_trace_pc_i,
	input wire logic exec_valid_i,
	input wire logic [7:0] exec_data_i,
	output logic exec_ready_o,
	input wire logic inst_valid_i,
	input wire logic [7:0] inst_data_i,
	output logic inst_ready_o,
	output logic [dap_fabric_pkg::TRACE_W-1:0] trace_data_o,
	output logic trace_ctl_o,
	input wire logic [dap_fabric_pkg::CT_CH-1:0] lp_trig_i,
	output logic [dap_fabric_pkg::CT_CH-1:0] lp_trig_o,
	input wire logic [dap_fabric_pkg::CT_CH-1:0] hp_trig_i,
	output logic [dap_fabric_pkg::CT_CH-1:0] hp_trig_o
);
	import dap_fabric_pkg::*;
	localparam int MTB_IDX_W = $clog2(MTB_DEPTH);
	localparam logic [MTB_IDX_W-1:0] MTB_LAST = MTB_IDX_W'(MTB_DEPTH - 1);

	typedef enum logic [1:0] {S_IDLE, S_BUS, S_REPLY} acc_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: stays powered in deep sleep

	logic [2:0] sys_state_l;
	logic sys_ready_l;
	logic link_take;
	logic ap_launch;
	logic ap_done_l;
	logic jtag_por_q;
	logic [1:0] ctl_q;
	logic [1:0] ap_sel_q;
	logic [ADDR_W-1:0] addr_q;
	logic [31:0] wdata_q;
	logic write_q;
	logic [31:0] dp_status;
	logic res_fault_q;
	logic [31:0] res_rdata_q;

	level_sync3 #(.WIDTH(3)) u_state_to_link (
		.clock_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.async_i({active_mode_i, debug_pwr_ack_i, system_pwr_ack_i}),
		.sync_o(sys_state_l)
	);

	assign sys_ready_l = sys_state_l[1] & sys_state_l[0];
	assign link_take = link_req_i & ~link_busy_o;
	assign ap_launch = link_take & ~link_dp_i & sys_ready_l;

	always_comb begin
		dp_status = '0;
		dp_status[DBG_REQ_BIT] = ctl_q[0];
		dp_status[DBG_ACK_BIT] = sys_state_l[1];
		dp_status[SYS_REQ_BIT] = ctl_q[1];
		dp_status[SYS_ACK_BIT] = sys_state_l[0];
	end

	// Fields stay put while busy, so the slow side reads them after its pulse
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ap_sel_q <= AP_LP;
			addr_q <= '0;
			wdata_q <= '0;
			write_q <= 1'b0;
		end else if (link_take) begin
			ap_sel_q <= link_ap_sel_i;
			addr_q <= link_addr_i;
			wdata_q <= link_wdata_i;
			write_q <= link_write_i;
		end
	end

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl_q <= CTL_RST;
			link_busy_o <= 1'b0;
			link_done_o <= 1'b0;
			link_fault_o <= 1'b0;
			link_rdata_o <= '0;
		end else begin
			link_done_o <= 1'b0;
			if (link_take && link_dp_i) begin
				link_done_o <= 1'b1;
				link_fault_o <= 1'b0;
				link_rdata_o <= dp_status;
				if (link_write_i) begin
					ctl_q <= {link_wdata_i[SYS_REQ_BIT], link_wdata_i[DBG_REQ_BIT]};
				end
			end else if (link_take && !sys_ready_l) begin
				link_done_o <= 1'b1;
				link_fault_o <= 1'b1;
				link_rdata_o <= '0;
			end else if (ap_launch) begin
				link_busy_o <= 1'b1;
			end else if (ap_done_l) begin
				link_busy_o <= 1'b0;
				link_done_o <= 1'b1;
				link_fault_o <= res_fault_q;
				link_rdata_o <= res_rdata_q;
			end
		end
	end

	// Shared pins: the listener's choice picks one protocol only
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			jtag_por_q <= 1'b0;
			swd_active_o <= 1'b0;
			jtag_active_o <= 1'b0;
		end else begin
			jtag_por_q <= 1'b1;
			swd_active_o <= link_swd_sel_i;
			jtag_active_o <= ~link_swd_sel_i & jtag_por_q & sys_state_l[2];
		end
	end

	AST_LINK_EXCLUSIVE: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		!(swd_active_o && jtag_active_o))
		else $error("both link protocols active");
	AST_JTAG_ACTIVE_ONLY: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		jtag_active_o |-> $past(sys_state_l[2]) && $past(jtag_por_q))
		else $error("four-wire link active outside active mode");
	AST_ASLEEP_FAULT: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		link_take && !link_dp_i && !sys_ready_l |=> link_done_o && link_fault_o && !link_busy_o)
		else $error("access while asleep not refused");

	////////////////////////////////////////////////////////////////////////////////
	// Crossings between link and system clocks

	logic [1:0] ctl_s;
	logic acc_pulse_s;
	logic done_launch_s;

	level_sync3 #(.WIDTH(2)) u_ctl_to_sys (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(ctl_q),
		.sync_o(ctl_s)
	);

	pulse_handshake u_acc_hs (
		.src_clk_i(link_clk_i),
		.dst_clk_i(clock_i),
		.reset_n_i(reset_n_i),
		.src_pulse_i(ap_launch),
		.src_busy_o(),
		.dst_pulse_o(acc_pulse_s)
	);

	pulse_handshake u_done_hs (
		.src_clk_i(clock_i),
		.dst_clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.src_pulse_i(done_launch_s),
		.src_busy_o(),
		.dst_pulse_o(ap_done_l)
	);

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			debug_power_up_request_o <= 1'b0;
			system_power_up_request_o <= 1'b0;
		end else begin
			debug_power_up_request_o <= ctl_s[0];
			system_power_up_request_o <= ctl_s[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access port routing and local registers

	logic [2:0] ap_en_q;
	logic policy_seen_q;
	logic sel_ok;
	logic local_hit;
	logic [31:0] local_data;
	logic mtb_win;
	logic mtb_clear_q;
	acc_state_t state_q;
	logic [31:0] mtb_mem [MTB_DEPTH];
	logic [MTB_IDX_W-1:0] wptr_q;
	logic mtb_full_q;
	logic trace_on_q;
	logic capture;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ap_en_q <= AP_EN_RST;
			policy_seen_q <= 1'b0;
		end else if (policy_valid_i) begin
			ap_en_q <= policy_ap_en_i;
			policy_seen_q <= 1'b1;
		end
	end

	assign mtb_win = (ap_sel_q == AP_LP) && (addr_q[11:10] == MTB_WIN);

	always_comb begin
		case (ap_sel_q)
			AP_LP: sel_ok = ap_en_q[0];
			AP_HP: sel_ok = ap_en_q[1];
			AP_SYS: sel_ok = ap_en_q[2];
			default: sel_ok = 1'b0;
		endcase
		local_hit = 1'b1;
		local_data = '0;
		if (addr_q == ROM_PTR_OFS) begin
			case (ap_sel_q)
				AP_LP: local_data = LP_ROM_BASE;
				AP_HP: local_data = HP_ROM_BASE;
				default: local_data = SYS_ROM_BASE;
			endcase
		end else if (ap_sel_q == AP_SYS && addr_q == ROM_ENTRY0_OFS) begin
			local_data = ROM_END_MARK;
		end else if (ap_sel_q == AP_SYS && addr_q == ROM_PID0_OFS) begin
			local_data = ID_MAKER;
		end else if (ap_sel_q == AP_SYS && addr_q == ROM_PID1_OFS) begin
			local_data = ID_PART;
		end else if (ap_sel_q == AP_SYS && addr_q == ROM_REV_OFS) begin
			local_data = ID_REVISION;
		end else if (ap_sel_q == AP_SYS && addr_q == ROM_CID_OFS) begin
			local_data = ID_COMPONENT;
		end else if (mtb_win) begin
			local_data = mtb_mem[addr_q[2 +: MTB_IDX_W]];
		end else begin
			local_hit = 1'b0;
		end
	end

	// Bus wait has no timeout; a hung port holds the link busy
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= S_IDLE;
			ap_req_o <= '0;
			ap_write_o <= 1'b0;
			ap_addr_o <= '0;
			ap_wdata_o <= '0;
			external_peripheral_bus_sel_o <= 1'b0;
			res_fault_q <= 1'b0;
			res_rdata_q <= '0;
			done_launch_s <= 1'b0;
			mtb_clear_q <= 1'b0;
		end else begin
			done_launch_s <= 1'b0;
			mtb_clear_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (acc_pulse_s) begin
						state_q <= S_REPLY;
						res_fault_q <= 1'b0;
						res_rdata_q <= '0;
						if (!sel_ok) begin
							res_fault_q <= 1'b1;
						end else if (local_hit) begin
							res_rdata_q <= write_q ? '0 : local_data;
							mtb_clear_q <= write_q & mtb_win;
						end else begin
							ap_req_o <= 3'h1 << ap_sel_q;
							ap_write_o <= write_q;
							ap_addr_o <= addr_q;
							ap_wdata_o <= wdata_q;
							external_peripheral_bus_sel_o <= (ap_sel_q == AP_HP) &&
								(addr_q[11:10] == PERIPH_WIN);
							state_q <= S_BUS;
						end
					end
				end
				S_BUS: begin
					if (ap_ack_i) begin
						ap_req_o <= '0;
						external_peripheral_bus_sel_o <= 1'b0;
						res_rdata_q <= ap_rdata_i;
						state_q <= S_REPLY;
					end
				end
				S_REPLY: begin
					done_launch_s <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	AST_ONE_AP: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$onehot0(ap_req_o))
		else $error("more than one access port selected");
	AST_AP_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(|ap_req_o) && !ap_ack_i |=> $stable(ap_req_o) && $stable(ap_addr_o))
		else $error("access port request dropped before acknowledge");
	AST_LP_DEFAULT_OFF: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!policy_seen_q |-> !ap_req_o[AP_LP])
		else $error("low-power core port used before policy");
	AST_PERIPH_HP_ONLY: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		external_peripheral_bus_sel_o |-> ap_req_o[AP_HP])
		else $error("peripheral bus select without high-perf port");
	AST_ROM_PTR_LOCAL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(|ap_req_o) |-> ap_addr_o != ROM_PTR_OFS)
		else $error("root table pointer forwarded to bus");

	////////////////////////////////////////////////////////////////////////////////
	// Micro trace buffer and trace control

	logic [CT_CH-1:0] ch_event;

	assign capture = trace_on_q & lp_trace_valid_i;

	always_ff @(posedge clock_i) begin
		if (capture) begin
			mtb_mem[wptr_q] <= lp_trace_pc_i;
		end
	end

	// Capture beats a host clear landing in the same cycle
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wptr_q <= '0;
			mtb_full_q <= 1'b0;
		end else begin
			if (capture) begin
				wptr_q <= wptr_q + 1'b1;
			end else if (mtb_clear_q) begin
				wptr_q <= '0;
			end
			if (capture && wptr_q == MTB_LAST) begin
				mtb_full_q <= 1'b1;
			end else if (mtb_clear_q) begin
				mtb_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trace_on_q <= TRACE_ON_RST;
		end else if (ch_event[CH_HALT] || (capture && wptr_q == MTB_LAST)) begin
			trace_on_q <= 1'b0;
		end else if (ch_event[CH_RESTART] || mtb_clear_q) begin
			trace_on_q <= 1'b1;
		end
	end

	AST_TRACE_STOP_FULL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		capture && wptr_q == MTB_LAST |=> mtb_full_q && !trace_on_q)
		else $error("trace kept running at buffer full");

	////////////////////////////////////////////////////////////////////////////////
	// Trace port unit

	logic turn_q;
	logic pend_q;
	logic [3:0] hi_q;

	// Grant alternates so neither stream can starve the other
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trace_data_o <= '0;
			trace_ctl_o <= 1'b0;
			exec_ready_o <= 1'b0;
			inst_ready_o <= 1'b0;
			turn_q <= 1'b0;
			pend_q <= 1'b0;
			hi_q <= '0;
		end else if (pend_q) begin
			trace_data_o <= hi_q;
			pend_q <= 1'b0;
			exec_ready_o <= ~turn_q;
			inst_ready_o <= turn_q;
		end else if ((exec_ready_o && exec_valid_i) || (inst_ready_o && inst_valid_i)) begin
			trace_data_o <= exec_ready_o ? exec_data_i[3:0] : inst_data_i[3:0];
			hi_q <= exec_ready_o ? exec_data_i[7:4] : inst_data_i[7:4];
			trace_ctl_o <= 1'b1;
			pend_q <= 1'b1;
			exec_ready_o <= 1'b0;
			inst_ready_o <= 1'b0;
			turn_q <= ~turn_q;
		end else begin
			trace_data_o <= '0;
			trace_ctl_o <= 1'b0;
			turn_q <= ~turn_q;
			exec_ready_o <= turn_q;
			inst_ready_o <= ~turn_q;
		end
	end

	AST_TPU_NIBBLES: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		exec_ready_o && exec_valid_i |=> (trace_ctl_o && !exec_ready_o) ##1 trace_ctl_o)
		else $error("trace byte not sent as two nibbles");

	////////////////////////////////////////////////////////////////////////////////
	// Cross trigger matrix (slow) and high-perf trigger interface (fast)

	logic [CT_CH-1:0] hp_in_s;
	logic [CT_CH-1:0] hp_out_f;

	genvar ch;
	generate
		for (ch = 0; ch < CT_CH; ch++) begin : g_ch
			pulse_handshake u_hp_up (
				.src_clk_i(fast_clk_i),
				.dst_clk_i(clock_i),
				.reset_n_i(reset_n_i),
				.src_pulse_i(hp_trig_i[ch]),
				.src_busy_o(),
				.dst_pulse_o(hp_in_s[ch])
			);
			pulse_handshake u_hp_down (
				.src_clk_i(clock_i),
				.dst_clk_i(fast_clk_i),
				.reset_n_i(reset_n_i),
				.src_pulse_i(ch_event[ch]),
				.src_busy_o(),
				.dst_pulse_o(hp_out_f[ch])
			);
		end
	endgenerate

	assign ch_event = lp_trig_i | hp_in_s;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lp_trig_o <= '0;
		end else begin
			lp_trig_o <= ch_event;
		end
	end

	always_ff @(posedge fast_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hp_trig_o <= '0;
		end else begin
			hp_trig_o <= hp_out_f;
		end
	end

	AST_HALT_FANOUT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		lp_trig_i[CH_HALT] |=> lp_trig_o[CH_HALT])
		else $error("halt channel not broadcast");
endmodule
`default_nettype wire

// file: tb/debug_host_model.sv
// Debug host model: free-running link clock and abstract access requests
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
	input wire logic busy_i,
	input wire logic done_i,
	input wire logic fault_i,
	input wire logic [31:0] rdata_i,
	output logic clk_o,
	output logic req_o,
	output logic dp_o,
	output logic write_o,
	output logic [1:0] ap_o,
	output logic [11:0] addr_o,
	output logic [31:0] wdata_o
);
	logic [31:0] rd;
	logic flt;
	logic hung = 1'b0;
	initial begin
		clk_o = 1'b0;
		req_o = 1'b0;
		{dp_o, write_o, ap_o, addr_o, wdata_o} = '0;
		#7;
		forever #62.5 clk_o = ~clk_o;
	end
	// Address and write data scrambled once released so stale values never look valid
	task automatic xfer(input logic dp, input logic wr, input logic [1:0] ap,
		input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_o);
		req_o <= 1'b1;
		{dp_o, write_o, ap_o, addr_o, wdata_o} <= {dp, wr, ap, a, wd};
		@(posedge clk_o);
		while (busy_i !== 1'b0 && n < 300) begin
			@(posedge clk_o);
			n++;
		end
		req_o <= 1'b0;
		{addr_o, wdata_o} <= {~a, ~wd};
		while (done_i !== 1'b1 && n < 300) begin
			@(posedge clk_o);
			n++;
		end
		rd = rdata_i;
		flt = fault_i;
		hung = (n >= 300);
	endtask
endmodule
`default_nettype wire

// file: tb/debug_access_port_fabric_tb.sv
// Self-checking bench for the debug access port fabric
`timescale 1ns/100ps
`default_nettype none
module debug_access_port_fabric_tb;
	import dap_fabric_pkg::*;
	localparam logic [31:0] HPB = 32'hE00F_F000;
	localparam logic [31:0] SYSB = 32'hF000_1000;
	localparam logic [31:0] MAKER = 32'h0000_0042; // arbitrary
	localparam logic [31:0] PC0 = 32'h1357_9BDF;
	int fail_count = 0;
	int check_count = 0;
	int hp_cnt = 0;
	logic clock_i = 1'b0, fast_clk_i = 1'b0, reset_n_i, link_swd_sel_i = 1'b0;
	logic active_mode_i = 1'b1, debug_pwr_ack_i = 1'b0, system_pwr_ack_i = 1'b0;
	logic policy_valid_i = 1'b0, ap_ack_i = 1'b0, lp_trace_valid_i = 1'b0;
	logic exec_valid_i = 1'b0, inst_valid_i = 1'b0, seen_pbus = 1'b0;
	logic [1:0] lp_trig_i = 2'h0, hp_trig_i = 2'h0;
	logic [2:0] policy_ap_en_i = 3'h0, seen_req = 3'h0;
	logic [7:0] exec_data_i = 8'h0, inst_data_i = 8'h0;
	logic [31:0] ap_rdata_i = 32'h0, lp_trace_pc_i = 32'h0, seen_wd = 32'h0;
	logic link_clk_i, link_req_i, link_dp_i, link_write_i, link_busy_o, link_done_o;
	logic link_fault_o, swd_active_o, jtag_active_o, debug_power_up_request_o;
	logic system_power_up_request_o, ap_write_o, external_peripheral_bus_sel_o;
	logic exec_ready_o, inst_ready_o, trace_ctl_o;
	logic [1:0] link_ap_sel_i, lp_trig_o, hp_trig_o;
	logic [2:0] ap_req_o;
	logic [3:0] trace_data_o;
	logic [11:0] link_addr_i, ap_addr_o;
	logic [31:0] link_wdata_i, link_rdata_o, ap_wdata_o;
	debug_access_port_fabric #(.MTB_DEPTH(8), .HP_ROM_BASE(HPB), .SYS_ROM_BASE(SYSB),
		.ID_MAKER(MAKER)) dut_u (
		.clock_i, .reset_n_i, .link_clk_i, .fast_clk_i, .link_swd_sel_i, .link_req_i,
		.link_dp_i, .link_write_i, .link_ap_sel_i, .link_addr_i, .link_wdata_i,
		.link_busy_o, .link_done_o, .link_fault_o, .link_rdata_o, .swd_active_o,
		.jtag_active_o, .active_mode_i, .debug_pwr_ack_i, .system_pwr_ack_i,
		.debug_power_up_request_o, .system_power_up_request_o, .policy_valid_i,
		.policy_ap_en_i, .ap_req_o, .ap_write_o, .ap_addr_o, .ap_wdata_o,
		.external_peripheral_bus_sel_o, .ap_ack_i, .ap_rdata_i, .lp_trace_valid_i,
		.lp_trace_pc_i, .exec_valid_i, .exec_data_i, .exec_ready_o, .inst_valid_i,
		.inst_data_i, .inst_ready_o, .trace_data_o, .trace_ctl_o, .lp_trig_i,
		.lp_trig_o, .hp_trig_i, .hp_trig_o);
	debug_host_model host_u (.busy_i(link_busy_o), .done_i(link_done_o),
		.fault_i(link_fault_o), .rdata_i(link_rdata_o), .clk_o(link_clk_i),
		.req_o(link_req_i), .dp_o(link_dp_i), .write_o(link_write_i),
		.ap_o(link_ap_sel_i), .addr_o(link_addr_i), .wdata_o(link_wdata_i));
	always #10 clock_i = ~clock_i;
	always #4 fast_clk_i = ~fast_clk_i;
	always @(posedge fast_clk_i) hp_cnt += (hp_trig_o[0] === 1'b1);
	// Power controller and bus stand-in; ack is one pulse per request
	always @(posedge clock_i) begin
		debug_pwr_ack_i <= debug_power_up_request_o;
		system_pwr_ack_i <= system_power_up_request_o;
		ap_ack_i <= (ap_req_o != 3'h0) && (ap_ack_i == 1'b0);
		ap_rdata_i <= {20'hA5A5A, ap_addr_o};
		if (ap_req_o != 3'h0) begin
			seen_req <= ap_req_o;
			seen_pbus <= external_peripheral_bus_sel_o;
		end
		if (ap_ack_i && ap_write_o) begin
			seen_wd <= ap_wdata_o;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wl(ref logic s, input logic v, input string nm);
		int n;
		n = 0;
		while (s !== v && n < 100) begin
			@(posedge link_clk_i);
			n++;
		end
		chk(nm, {31'h0, v}, {31'h0, s});
	endtask
	task automatic acc(input logic dp, input logic wr, input logic [1:0] ap,
		input logic [11:0] a, input logic [31:0] wd);
		host_u.xfer(dp, wr, ap, a, wd);
		if (host_u.hung) begin
			fail_count++;
			results();
		end
	endtask
	task automatic rd_chk(input logic [1:0] ap, input logic [11:0] a, input logic f,
		input logic [31:0] d, input string nm);
		acc(1'b0, 1'b0, ap, a, 32'h0);
		chk(nm, {31'h0, f}, {31'h0, host_u.flt});
		if (!f) chk(nm, d, host_u.rd);
	endtask
	task automatic bus_rd(input logic [1:0] ap, input logic [11:0] a, input logic [2:0] r,
		input logic e);
		rd_chk(ap, a, 1'b0, {20'hA5A5A, a}, "bus data");
		chk("ap select", {29'h0, r}, {29'h0, seen_req});
		chk("pbus select", {31'h0, e}, {31'h0, seen_pbus});
	endtask
	task automatic pol(input logic [2:0] v);
		@(posedge clock_i);
		policy_ap_en_i <= v;
		policy_valid_i <= 1'b1;
		@(posedge clock_i);
		policy_valid_i <= 1'b0;
		repeat (4) @(posedge link_clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_link();
		wl(jtag_active_o, 1'b1, "jtag default");
		@(posedge clock_i) active_mode_i <= 1'b0;
		wl(jtag_active_o, 1'b0, "jtag asleep");
		@(posedge clock_i) active_mode_i <= 1'b1;
		wl(jtag_active_o, 1'b1, "jtag awake");
		@(posedge link_clk_i) link_swd_sel_i <= 1'b1;
		wl(swd_active_o, 1'b1, "swd on");
		wl(jtag_active_o, 1'b0, "jtag off");
	endtask
	task automatic t_power();
		@(posedge clock_i) active_mode_i <= 1'b0;
		acc(1'b1, 1'b0, AP_LP, 12'h0, 32'h0);
		chk("status asleep", 32'h0, {28'h0, host_u.rd[31:28]});
		rd_chk(AP_SYS, ROM_PID0_OFS, 1'b1, 32'h0, "unpowered");
		@(posedge clock_i) active_mode_i <= 1'b1;
		acc(1'b1, 1'b1, AP_LP, 12'h0, 32'h5000_0000);
		wl(debug_power_up_request_o, 1'b1, "debug power");
		wl(system_power_up_request_o, 1'b1, "system power");
		repeat (8) @(posedge link_clk_i);
		acc(1'b1, 1'b0, AP_LP, 12'h0, 32'h0);
		chk("status on", 32'hF, {28'h0, host_u.rd[31:28]});
	endtask
	task automatic t_route();
		rd_chk(AP_HP, ROM_PTR_OFS, 1'b0, HPB, "hp rom");
		rd_chk(AP_SYS, ROM_PTR_OFS, 1'b0, SYSB, "sys rom");
		rd_chk(AP_LP, ROM_PTR_OFS, 1'b1, 32'h0, "lp closed");
		rd_chk(AP_SYS, ROM_PID0_OFS, 1'b0, MAKER, "maker");
		rd_chk(AP_SYS, ROM_ENTRY0_OFS, 1'b0, ROM_END_MARK, "entry");
		rd_chk(2'h3, 12'h010, 1'b1, 32'h0, "bad ap");
		bus_rd(AP_HP, 12'h010, 3'h2, 1'b0);
		bus_rd(AP_HP, 12'h810, 3'h2, 1'b1);
		bus_rd(AP_SYS, 12'h020, 3'h4, 1'b0);
		acc(1'b0, 1'b1, AP_SYS, 12'h040, 32'hC3C3_0F0F);
		chk("bus wdata", 32'hC3C3_0F0F, seen_wd);
		pol(3'h7);
		bus_rd(AP_LP, 12'h030, 3'h1, 1'b0);
		rd_chk(AP_LP, 12'h400, 1'b0, PC0, "trace word");
		pol(3'h0);
		rd_chk(AP_HP, 12'h010, 1'b1, 32'h0, "hp closed");
		rd_chk(AP_SYS, 12'h010, 1'b1, 32'h0, "sys closed");
	endtask
	task automatic t_trace(input logic s, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		{inst_valid_i, exec_valid_i, exec_data_i, inst_data_i} <= {s, ~s, d, d};
		@(posedge clock_i);
		while ((s ? inst_ready_o : exec_ready_o) !== 1'b1 && n < 20) begin
			@(posedge clock_i);
			n++;
		end
		{inst_valid_i, exec_valid_i, exec_data_i, inst_data_i} <= {2'h0, ~d, ~d};
		if (n >= 20) begin
			fail_count++;
			results();
		end
		#1 chk("nibble lo", {27'h0, 1'b1, d[3:0]}, {27'h0, trace_ctl_o, trace_data_o});
		@(posedge clock_i);
		#1 chk("nibble hi", {27'h0, 1'b1, d[7:4]}, {27'h0, trace_ctl_o, trace_data_o});
	endtask
	task automatic t_trig();
		int c;
		int h;
		for (int ch = 0; ch < 2; ch++) begin
			c = 0;
			@(posedge fast_clk_i) hp_trig_i <= 2'h1 << ch;
			@(posedge fast_clk_i) hp_trig_i <= 2'h0;
			repeat (60) begin
				@(posedge clock_i);
				c += (lp_trig_o[ch] === 1'b1);
			end
			chk("trig pulses", 32'h1, c);
		end
		h = hp_cnt;
		c = 0;
		@(posedge clock_i) lp_trig_i <= 2'h1;
		@(posedge clock_i) lp_trig_i <= 2'h0;
		repeat (60) @(posedge clock_i) c += (lp_trig_o[0] === 1'b1);
		chk("lp fanout", 32'h1, c);
		chk("hp fanout", 32'h1, hp_cnt - h);
	endtask
	initial begin
		reset_n_i <= 1'b0;
		repeat (6) @(posedge link_clk_i);
		@(posedge clock_i) reset_n_i <= 1'b1;
		@(posedge clock_i);
		{lp_trace_valid_i, lp_trace_pc_i} <= {1'b1, PC0};
		repeat (8) @(posedge clock_i);
		{lp_trace_valid_i, lp_trace_pc_i} <= {1'b0, ~PC0};
		t_link();
		t_power();
		t_route();
		t_trace(1'b0, 8'hAB);
		t_trace(1'b1, 8'h6C);
		t_trig();
		results();
	end
	initial begin
		#2000000;
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
